// ===== pkg/pdc_pkg.sv
// Shared constants and types for the decoder and port configuration block.
`default_nettype none
package pdc_pkg;
  // Decode input vector layout, low bit first.
  localparam int PDC_NIN       = 16;
  localparam int PDC_IN_ALE    = 0;
  localparam int PDC_IN_WR     = 1;
  localparam int PDC_IN_RD     = 2;
  localparam int PDC_IN_PAGE   = 3;
  localparam int PDC_IN_A16    = 7;
  localparam int PDC_IN_A11    = 11;
  // Product term slots in the shared term array.
  localparam int PDC_T_EPROM   = 0;
  localparam int PDC_T_SRAM    = 8;
  localparam int PDC_T_IOPORT  = 9;
  localparam int PDC_T_TIN     = 10;
  localparam int PDC_T_TAOUT   = 11;
  localparam int PDC_T_TWOUT   = 12;
  localparam int PDC_T_GRP_A   = 13;
  localparam int PDC_T_GRP_B   = 29;
  localparam int PDC_T_GRP_C   = 37;
  localparam int PDC_NTERMS    = 40;
  localparam int PDC_A_TERMS   = 4;
  localparam int PDC_B_TERMS   = 2;
  localparam int PDC_SYNC_W    = 32;
  // Port A register offsets from the I/O select base; also the bus index.
  localparam logic [4:0] PDC_OFF_PIN  = 5'h02;
  localparam logic [4:0] PDC_OFF_DIR  = 5'h04;
  localparam logic [4:0] PDC_OFF_DATA = 5'h06;
  localparam logic [5:0] PDC_IDX_STAT = 6'h08;
  localparam logic [7:0] PDC_DIR_RST  = 8'h00;
  localparam logic [7:0] PDC_DATA_RST = 8'h00;
  // Read and write signalling styles, strobe style bit then method bit.
  typedef enum logic [1:0] {
    PDC_STB_PULSES  = 2'b00,
    PDC_STB_ENABLE  = 2'b01,
    PDC_STB_RSVD    = 2'b10,
    PDC_STB_DSTROBE = 2'b11
  } pdc_strobe_t;
endpackage
`default_nettype wire

// ===== rtl/pdc_sync.sv
// Two-stage synchroniser for pin inputs.
`timescale 1ns/1ns
`default_nettype none
module pdc_sync
  import pdc_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  initial begin
    if (W < 1) $error("pdc_sync width must be at least one");
  end

  // The first stage feeds only the second stage.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/pdc_term_array.sv
// Programmable AND array: each term matches true, complement or ignore.
`timescale 1ns/1ns
`default_nettype none
module pdc_term_array
  import pdc_pkg::*;
#(
  parameter int NIN = 16,
  parameter int NT  = 40
) (
  input  wire logic [NIN-1:0]    in_vec,
  input  wire logic [NT*NIN-1:0] care,
  input  wire logic [NT*NIN-1:0] match,
  output var  logic [NT-1:0]     hit
);
  initial begin
    if (NIN < 1 || NT < 1) $error("pdc_term_array needs inputs and terms");
  end

  // A term is true when every cared input equals its programmed level.
  always_comb begin
    for (int t = 0; t < NT; t++) begin
      hit[t] = &(~care[t*NIN +: NIN] | ~(in_vec ^ match[t*NIN +: NIN]));
    end
  end
endmodule
`default_nettype wire

// ===== rtl/pdc_decoder_port.sv
// Address decode array with Port A pin logic and a Wishbone register slave.
//
// Overview of operation
// - Standby setting 0 and standby pin high deselects all and powers down.
// - Reset deselects every select and never enters a product term.
// - Eight EPROM bank selects, one product term each.
// - One SRAM select from a single product term.
// - One I/O port select from one product term sets register base.
// - Track mode: inbound select plus read drives Port A onto AD pins.
// - Track mode: address-out select plus ALE drives AD address to Port A.
// - Track mode: write-out select drives AD data to Port A.
// - External selects 0 to 3 each OR four product terms.
// - External selects 4 to 7 each OR two product terms.
// - External selects 8 to 10 use one term, routed to Port C.
// - Settings are fixed in operation; erased settings all read zero.
// - Bus width setting: 0 gives 8-bit, 1 gives 16-bit data bus.
// - Multiplex setting: 0 separate buses, 1 multiplexed address and data.
// - ALE polarity 0 high 1 low; reset polarity 0 low 1 high.
// - On the multiplexed bus, track setting 0 uses per-pin function; 1 puts port in track mode.
// - A16 to A19 latched or transparent; each is logic or address input.
// - Non-multiplexed low address transparent or ALE latched by setting.
// - Strobe style selects read/write pulses, enable or data strobe.
// - Per-pin settings for Port A, Port B and Port C functions.
// - I/O pin direction and data flops; flops and pin levels readable.
// - Address pins output a port address latch caught at ALE trailing edge.
// - Track mode with no condition leaves Port A released.
// - Pin, direction, data registers at base plus 2, 4, 6; pin read only.
`timescale 1ns/1ns
`default_nettype none
module pdc_decoder_port
  import pdc_pkg::*;
(
  input  wire logic                       CLK,
  input  wire logic                       RST_N,
  // Wishbone register slave.
  input  wire logic                       CYC_I,
  input  wire logic                       STB_I,
  input  wire logic                       WE_I,
  input  wire logic [7:0]                 ADR_I,
  input  wire logic [3:0]                 SEL_I,
  input  wire logic [31:0]                DAT_I,
  output var  logic [31:0]                DAT_O,
  output var  logic                       ACK_O,
  // Static configuration settings.
  input  wire logic                       BUS_WIDTH_CFG,
  input  wire logic                       MUXED_BUS_CFG,
  input  wire logic                       STANDBY_OR_ADDR_CFG,
  input  wire logic                       LATCH_STROBE_POLARITY_CFG,
  input  wire logic                       RESET_POLARITY_CFG,
  input  wire logic                       PORT_A_TRACK_CFG,
  input  wire logic [7:0]                 PORT_A_PIN_FUNC_CFG,
  input  wire logic [7:0]                 PORT_A_DRIVE_CFG,
  input  wire logic [7:0]                 PORT_B_PIN_FUNC_CFG,
  input  wire logic [7:0]                 PORT_B_DRIVE_CFG,
  input  wire logic [2:0]                 PORT_C_PIN_FUNC_CFG,
  input  wire logic                       UPPER_ADDR_LATCH_CFG,
  input  wire logic [3:0]                 UPPER_ADDR_LOGIC_CFG,
  input  wire logic                       NONMUX_ADDR_LATCH_CFG,
  input  wire logic                       STROBE_STYLE_CFG,
  input  wire logic                       RW_METHOD_CFG,
  input  wire logic [PDC_NTERMS*PDC_NIN-1:0] TERM_CARE_CFG,
  input  wire logic [PDC_NTERMS*PDC_NIN-1:0] TERM_MATCH_CFG,
  // Host bus pins.
  input  wire logic [15:0]                AD_I,
  output var  logic [7:0]                 AD_O,
  output var  logic                       AD_OE,
  input  wire logic                       STANDBY_PIN,
  input  wire logic                       RD_PIN,
  input  wire logic                       WR_PIN,
  input  wire logic                       ALE_PIN,
  input  wire logic                       RESET_PIN,
  input  wire logic [3:0]                 PAGE_INPUTS,
  // Ports.
  input  wire logic [7:0]                 PORT_A_I,
  output var  logic [7:0]                 PORT_A_O,
  output var  logic [7:0]                 PORT_A_OE,
  output var  logic [7:0]                 PORT_B_SEL_O,
  output var  logic [7:0]                 PORT_B_SEL_OE,
  input  wire logic [2:0]                 PORT_C_I,
  output var  logic [2:0]                 PORT_C_O,
  output var  logic [2:0]                 PORT_C_OE,
  // Internal selects.
  output var  logic [7:0]                 EPROM_BANK_SELECTS,
  output var  logic                       SRAM_SELECT,
  output var  logic                       IO_PORT_SELECT,
  output var  logic [10:0]                EXT_SELECT_N,
  output var  logic                       POWER_DOWN
);
  logic [PDC_SYNC_W-1:0] sync_q;
  logic [15:0]           s_ad;
  logic [7:0]            s_pa;
  logic [2:0]            s_pc;
  logic                  s_stby, s_rd, s_wr, s_ale, s_rst;
  logic                  rd_act, wr_act, ale_act, dev_reset, standby;
  logic                  off_all;
  logic [15:0]           ale_hold_q;
  logic [3:0]            up_hold_q;
  logic [15:0]           addr;
  logic [3:0]            up_live, up_addr;
  logic [15:0]           lo_pick, hi_pick, up_pick;
  logic                  ale_prev_q, wr_prev_q;
  logic [7:0]            pa_addr_q, wr_data_q;
  logic [4:0]            wr_off_q;
  logic [PDC_NIN-1:0]    dec_in;
  logic [PDC_NTERMS-1:0] hit;
  logic [10:0]           ext_sel;
  logic [7:0]            dir_q, data_q;
  logic                  io_sel, host_rd, host_wr;
  logic                  wb_req, wb_wr;
  logic [7:0]            pa_o_d, pa_oe_d, ad_o_d;
  logic                  ad_oe_d;
  pdc_strobe_t           style;

  // Picks the latched value while latching is on and ALE is idle, else the live pin value.
  function automatic logic [15:0] pick(input logic lat_en,
                                       input logic ale,
                                       input logic [15:0] live,
                                       input logic [15:0] held);
    pick = (lat_en && !ale) ? held : live;
  endfunction

  // Port A register read by offset; unknown offsets read zero.
  function automatic logic [7:0] pa_read(input logic [4:0] off,
                                         input logic [7:0] pin,
                                         input logic [7:0] dir,
                                         input logic [7:0] dat);
    case (off)
      PDC_OFF_PIN:  pa_read = pin;
      PDC_OFF_DIR:  pa_read = dir;
      PDC_OFF_DATA: pa_read = dat;
      default:      pa_read = 8'h00;
    endcase
  endfunction

  // Open drain pins only pull low; CMOS pins drive both levels.
  function automatic logic od_en(input logic od, input logic en,
                                 input logic val);
    od_en = od ? (en & ~val) : en;
  endfunction

  // All pin inputs except PAGE_INPUTS are resynchronised before any logic looks at them.
  pdc_sync #(.W(PDC_SYNC_W)) u_sync (
    .clk   (CLK),
    .rst_n (RST_N),
    .d     ({AD_I, PORT_A_I, PORT_C_I, STANDBY_PIN, RD_PIN, WR_PIN,
             ALE_PIN, RESET_PIN}),
    .q     (sync_q)
  );
  assign {s_ad, s_pa, s_pc, s_stby, s_rd, s_wr, s_ale, s_rst} = sync_q;

  // Strobe decoding by signalling style; the unused code acts as pulses.
  assign style = pdc_strobe_t'({STROBE_STYLE_CFG, RW_METHOD_CFG});
  always_comb begin
    case (style)
      PDC_STB_ENABLE: begin
        rd_act = s_rd & s_wr;
        wr_act = s_rd & ~s_wr;
      end
      PDC_STB_DSTROBE: begin
        rd_act = ~s_rd & s_wr;
        wr_act = ~s_rd & ~s_wr;
      end
      default: begin
        rd_act = ~s_rd;
        wr_act = ~s_wr;
      end
    endcase
  end

  // Polarity of ALE and of the reset pin; standby only in standby mode.
  assign ale_act   = s_ale ^ LATCH_STROBE_POLARITY_CFG;
  assign dev_reset = RESET_POLARITY_CFG ? s_rst : ~s_rst;
  assign standby   = ~STANDBY_OR_ADDR_CFG & s_stby;
  assign off_all   = dev_reset | standby;
  assign POWER_DOWN = standby;

  // Address holding registers follow the pins while ALE is active.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ale_hold_q <= 16'h0000;
      up_hold_q  <= 4'h0;
    end else if (ale_act) begin
      ale_hold_q <= s_ad;
      up_hold_q  <= up_live;
    end
  end

  // Low address: latched in mux mode, by setting otherwise; the high
  // byte is multiplexed only on the 16-bit multiplexed bus.
  always_comb begin
    lo_pick = pick(MUXED_BUS_CFG | NONMUX_ADDR_LATCH_CFG, ale_act,
                   s_ad, ale_hold_q);
    hi_pick = pick(MUXED_BUS_CFG ? BUS_WIDTH_CFG : NONMUX_ADDR_LATCH_CFG,
                   ale_act, s_ad, ale_hold_q);
    addr    = {hi_pick[15:8], lo_pick[7:0]};
  end

  // A16 to A18 come from Port C inputs, A19 from the standby pin.
  always_comb begin
    up_live = {s_stby & STANDBY_OR_ADDR_CFG, s_pc & ~PORT_C_PIN_FUNC_CFG};
    up_pick = pick(UPPER_ADDR_LATCH_CFG, ale_act, {12'h000, up_live},
                   {12'h000, up_hold_q});
    for (int i = 0; i < 4; i++) begin
      up_addr[i] = UPPER_ADDR_LOGIC_CFG[i] ? up_pick[i] : up_live[i];
    end
  end

  // Port address latch loads on the trailing edge of ALE.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ale_prev_q <= 1'b0;
      pa_addr_q  <= 8'h00;
    end else begin
      ale_prev_q <= ale_act;
      if (ale_prev_q && !ale_act) begin
        pa_addr_q <= ale_hold_q[7:0];
      end
    end
  end

  // Decode input vector; reset has no place in it.
  always_comb begin
    dec_in = '0;
    dec_in[PDC_IN_ALE]        = ale_act;
    dec_in[PDC_IN_WR]         = wr_act;
    dec_in[PDC_IN_RD]         = rd_act;
    dec_in[PDC_IN_PAGE +: 4]  = PAGE_INPUTS;
    dec_in[PDC_IN_A16 +: 4]   = up_addr;
    dec_in[PDC_IN_A11 +: 5]   = addr[15:11];
  end

  pdc_term_array #(.NIN(PDC_NIN), .NT(PDC_NTERMS)) u_terms (
    .in_vec (dec_in),
    .care   (TERM_CARE_CFG),
    .match  (TERM_MATCH_CFG),
    .hit    (hit)
  );

  // External selects: wide, narrow and single-term groups.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ext_sel[i] = |hit[PDC_T_GRP_A + i*PDC_A_TERMS +: PDC_A_TERMS];
      ext_sel[4+i] = |hit[PDC_T_GRP_B + i*PDC_B_TERMS +: PDC_B_TERMS];
    end
    ext_sel[10:8] = hit[PDC_T_GRP_C +: 3];
  end

  // Registered selects, all forced inactive under reset or standby.
  always_ff @(posedge CLK) begin
    if (!RST_N || off_all) begin
      EPROM_BANK_SELECTS <= 8'h00;
      SRAM_SELECT        <= 1'b0;
      IO_PORT_SELECT     <= 1'b0;
      EXT_SELECT_N       <= 11'h7ff;
    end else begin
      EPROM_BANK_SELECTS <= hit[PDC_T_EPROM +: 8];
      SRAM_SELECT        <= hit[PDC_T_SRAM];
      IO_PORT_SELECT     <= hit[PDC_T_IOPORT];
      EXT_SELECT_N       <= ~ext_sel;
    end
  end

  // Host access to Port A registers inside the I/O select space.
  assign io_sel  = hit[PDC_T_IOPORT] & ~off_all;
  assign host_rd = io_sel & rd_act
                 & (pa_read(addr[4:0], 8'hff, 8'hff, 8'hff) != 8'h00);
  assign host_wr = wr_prev_q & ~wr_act;

  // Write data and offset are captured while the write strobe is active.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wr_prev_q <= 1'b0;
      wr_data_q <= 8'h00;
      wr_off_q  <= 5'h00;
    end else begin
      wr_prev_q <= wr_act & io_sel;
      if (wr_act && io_sel) begin
        wr_data_q <= MUXED_BUS_CFG ? s_ad[7:0] : s_pa;
        wr_off_q  <= addr[4:0];
      end
    end
  end

  // Wishbone handshake: one answer per request, dropped the next cycle.
  assign wb_req = CYC_I & STB_I & ~ACK_O;
  assign wb_wr  = wb_req & WE_I & SEL_I[0];
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h0000_0000;
    end else begin
      ACK_O <= wb_req;
      if (wb_req && !WE_I) begin
        if (ADR_I[7:2] == PDC_IDX_STAT) begin
          DAT_O <= {9'h000, POWER_DOWN, IO_PORT_SELECT, SRAM_SELECT, 1'b0,
                    ~EXT_SELECT_N, EPROM_BANK_SELECTS};
        end else if (ADR_I[7] == 1'b0) begin
          DAT_O <= {24'h000000,
                    pa_read(ADR_I[6:2], s_pa, dir_q, data_q)};
        end else begin
          DAT_O <= 32'h0000_0000;
        end
      end
    end
  end

  // Direction and data flops; a host pin write wins over Wishbone.
  always_ff @(posedge CLK) begin
    if (!RST_N || dev_reset) begin
      dir_q  <= PDC_DIR_RST;
      data_q <= PDC_DATA_RST;
    end else if (host_wr) begin
      if (wr_off_q == PDC_OFF_DIR)  dir_q  <= wr_data_q;
      if (wr_off_q == PDC_OFF_DATA) data_q <= wr_data_q;
    end else if (wb_wr && ADR_I[7] == 1'b0) begin
      if (ADR_I[6:2] == PDC_OFF_DIR)  dir_q  <= DAT_I[7:0];
      if (ADR_I[6:2] == PDC_OFF_DATA) data_q <= DAT_I[7:0];
    end
  end

  // Pin drive for Port A and the low AD byte.
  always_comb begin
    pa_o_d  = 8'h00;
    pa_oe_d = 8'h00;
    ad_o_d  = 8'h00;
    ad_oe_d = 1'b0;
    if (!MUXED_BUS_CFG) begin
      // Port A is the data bus; it drives only register reads.
      if (host_rd) begin
        pa_o_d  = pa_read(addr[4:0], s_pa, dir_q, data_q);
        pa_oe_d = 8'hff;
      end
    end else if (PORT_A_TRACK_CFG) begin
      if (off_all) begin
        pa_oe_d = 8'h00;
      end else if (hit[PDC_T_TIN] && rd_act) begin
        ad_o_d  = s_pa;
        ad_oe_d = 1'b1;
      end else if (hit[PDC_T_TAOUT] && ale_act) begin
        pa_o_d  = s_ad[7:0];
        pa_oe_d = 8'hff;
      end else if (hit[PDC_T_TWOUT]) begin
        pa_o_d  = s_ad[7:0];
        pa_oe_d = 8'hff;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        pa_o_d[i]  = PORT_A_PIN_FUNC_CFG[i] ? pa_addr_q[i] : data_q[i];
        pa_oe_d[i] = PORT_A_PIN_FUNC_CFG[i] | dir_q[i];
      end
    end
    if (MUXED_BUS_CFG && host_rd && !ad_oe_d) begin
      ad_o_d  = pa_read(addr[4:0], s_pa, dir_q, data_q);
      ad_oe_d = 1'b1;
    end
    for (int i = 0; i < 8; i++) begin
      pa_oe_d[i] = od_en(PORT_A_DRIVE_CFG[i], pa_oe_d[i], pa_o_d[i]);
      pa_o_d[i]  = pa_o_d[i] & ~PORT_A_DRIVE_CFG[i];
    end
  end

  // Registered pin outputs.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PORT_A_O  <= 8'h00;
      PORT_A_OE <= 8'h00;
      AD_O      <= 8'h00;
      AD_OE     <= 1'b0;
    end else begin
      PORT_A_O  <= pa_o_d;
      PORT_A_OE <= pa_oe_d;
      AD_O      <= ad_o_d;
      AD_OE     <= ad_oe_d;
    end
  end

  // Port B select outputs and Port C select outputs.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PORT_B_SEL_O  <= 8'hff;
      PORT_B_SEL_OE <= 8'h00;
      PORT_C_O      <= 3'h7;
      PORT_C_OE     <= 3'h0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        PORT_B_SEL_O[i]  <= EXT_SELECT_N[i] & ~PORT_B_DRIVE_CFG[i];
        PORT_B_SEL_OE[i] <= od_en(PORT_B_DRIVE_CFG[i],
                                  ~PORT_B_PIN_FUNC_CFG[i]
                                  & ~(~MUXED_BUS_CFG & BUS_WIDTH_CFG),
                                  EXT_SELECT_N[i]);
      end
      PORT_C_O  <= EXT_SELECT_N[10:8];
      PORT_C_OE <= PORT_C_PIN_FUNC_CFG;
    end
  end

  // Settings are plain inputs; all-zero inputs give the erased behaviour.
  initial begin
    if (PDC_NTERMS != PDC_T_GRP_C + 3) $error("term slot layout broken");
  end
endmodule
`default_nettype wire

// ===== tb/pdc_decoder_port_monitor.sv
// Port checker for the decoder block, bound to its top module.
`timescale 1ns/1ns
`default_nettype none
module pdc_chk
  import pdc_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        CYC_I,
  input wire logic        STB_I,
  input wire logic        ACK_O,
  input wire logic [31:0] DAT_O,
  input wire logic        STANDBY_OR_ADDR_CFG,
  input wire logic        RESET_POLARITY_CFG,
  input wire logic        RESET_PIN,
  input wire logic        POWER_DOWN,
  input wire logic [7:0]  EPROM_BANK_SELECTS,
  input wire logic        SRAM_SELECT,
  input wire logic        IO_PORT_SELECT,
  input wire logic [10:0] EXT_SELECT_N
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // A request still waiting for its answer, and every select released.
  sequence s_req;
    CYC_I && STB_I && !ACK_O;
  endsequence
  sequence s_dsel;
    EPROM_BANK_SELECTS == 8'h00 && !SRAM_SELECT && !IO_PORT_SELECT
      && EXT_SELECT_N == 11'h7ff;
  endsequence
  property p_ack; s_req |=> ACK_O; endproperty
  property p_ack_one; ACK_O |=> !ACK_O; endproperty
  property p_ack_src; ACK_O |-> $past(CYC_I) && $past(STB_I); endproperty
  property p_dat_hi; ACK_O |-> DAT_O[31:23] == 9'h000; endproperty
  property p_rst; disable iff (1'b0) !RST_N |=> s_dsel; endproperty
  property p_pin_rst;
    (RESET_PIN == RESET_POLARITY_CFG) [*6] |-> s_dsel;
  endproperty
  property p_pd; (POWER_DOWN && !STANDBY_OR_ADDR_CFG) [*3] |-> s_dsel;
  endproperty
  property p_pd_cfg; STANDBY_OR_ADDR_CFG |-> !POWER_DOWN; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  a_ack_one: assert property (p_ack_one) else $error("ack long");
  a_ack_src: assert property (p_ack_src) else $error("ack unasked");
  a_dat_hi: assert property (p_dat_hi) else $error("read high bits");
  a_rst: assert property (p_rst) else $error("reset select");
  a_pin_rst: assert property (p_pin_rst) else $error("pin reset");
  a_pd: assert property (p_pd) else $error("standby select");
  a_pd_cfg: assert property (p_pd_cfg) else $error("standby mode");
endmodule
bind pdc_decoder_port pdc_chk u_chk (
  .CLK(CLK), .RST_N(RST_N), .CYC_I(CYC_I), .STB_I(STB_I),
  .ACK_O(ACK_O), .DAT_O(DAT_O), .STANDBY_OR_ADDR_CFG(STANDBY_OR_ADDR_CFG),
  .RESET_POLARITY_CFG(RESET_POLARITY_CFG), .RESET_PIN(RESET_PIN),
  .POWER_DOWN(POWER_DOWN), .EPROM_BANK_SELECTS(EPROM_BANK_SELECTS),
  .SRAM_SELECT(SRAM_SELECT), .IO_PORT_SELECT(IO_PORT_SELECT),
  .EXT_SELECT_N(EXT_SELECT_N));
`default_nettype wire

// ===== tb/pdc_host_model.sv
// Host bus model: multiplexed address phase with ALE and idle strobes.
`timescale 1ns/1ns
`default_nettype none
module pdc_host
  import pdc_pkg::*;
(
  input  wire logic        clk,
  output var  logic [15:0] ad,
  output var  logic        ale,
  output var  logic        rd_n,
  output var  logic        wr_n,
  output var  logic [3:0]  page
);
  // The bus idles with both strobes inactive and ALE low.
  initial begin
    ad = 16'h0000;
    ale = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    page = 4'h0;
  end
  // Address and page stand before ALE rises and stay after it falls.
  task automatic addr_cycle(input logic [15:0] a, input logic [3:0] p);
    @(posedge clk);
    ad <= a;
    page <= p;
    @(posedge clk);
    ale <= 1'b1;
    repeat (3) @(posedge clk);
    ale <= 1'b0;
  endtask
  // Drives the read strobe at the next edge; low means read active.
  task automatic set_rd(input logic v);
    @(posedge clk);
    rd_n <= v;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the decode array and Port A logic.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import pdc_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic        stby = 1'b0;
  logic        rst_pin = 1'b1;
  logic        mux = 1'b1, sbc = 1'b0, alp = 1'b0, rpc = 1'b0, trk = 1'b0;
  logic [7:0]  pa_fn = 8'hf0, pa_od = 8'h00, pb_fn = 8'h00, pb_od = 8'h00;
  logic [3:0]  up_lg = 4'h0;
  logic [2:0]  pc_fn = 3'h7;
  logic [31:0] rd;
  logic [31:0] dat_o;
  logic        ack;
  logic [PDC_NTERMS*PDC_NIN-1:0] care;
  logic [PDC_NTERMS*PDC_NIN-1:0] match;
  wire  [15:0] ad;
  wire  [3:0]  page;
  wire         ale, rd_n, wr_n, sram, iosel, pd, ad_oe;
  wire  [7:0]  pa_o, pa_oe, pa_pin, pb_o, pb_oe, eprom, ad_o;
  wire  [2:0]  pc_o, pc_oe, pc_pin;
  wire  [10:0] ext_n;
  int          fail_count = 0;
  int          samples_checked = 0;
  // Pin levels seen by the block: driven bits, else the outside level.
  assign pa_pin = (pa_oe & pa_o) | (~pa_oe & 8'h96);
  assign pc_pin = (pc_oe & pc_o) | (~pc_oe & 3'h5);
  always #5 clk = ~clk;
  pdc_host host (.clk(clk), .ad(ad), .ale(ale), .rd_n(rd_n),
    .wr_n(wr_n), .page(page));
  pdc_decoder_port uut (
    .CLK(clk), .RST_N(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(dat_o), .ACK_O(ack),
    .BUS_WIDTH_CFG(1'b0), .MUXED_BUS_CFG(mux),
    .STANDBY_OR_ADDR_CFG(sbc), .LATCH_STROBE_POLARITY_CFG(alp),
    .RESET_POLARITY_CFG(rpc), .PORT_A_TRACK_CFG(trk),
    .PORT_A_PIN_FUNC_CFG(pa_fn), .PORT_A_DRIVE_CFG(pa_od),
    .PORT_B_PIN_FUNC_CFG(pb_fn), .PORT_B_DRIVE_CFG(pb_od),
    .PORT_C_PIN_FUNC_CFG(pc_fn), .UPPER_ADDR_LATCH_CFG(1'b0),
    .UPPER_ADDR_LOGIC_CFG(up_lg), .NONMUX_ADDR_LATCH_CFG(1'b0),
    .STROBE_STYLE_CFG(1'b0), .RW_METHOD_CFG(1'b0),
    .TERM_CARE_CFG(care), .TERM_MATCH_CFG(match), .AD_I(ad), .AD_O(ad_o),
    .AD_OE(ad_oe), .STANDBY_PIN(stby), .RD_PIN(rd_n), .WR_PIN(wr_n),
    .ALE_PIN(ale), .RESET_PIN(rst_pin), .PAGE_INPUTS(page),
    .PORT_A_I(pa_pin), .PORT_A_O(pa_o), .PORT_A_OE(pa_oe),
    .PORT_B_SEL_O(pb_o), .PORT_B_SEL_OE(pb_oe), .PORT_C_I(pc_pin),
    .PORT_C_O(pc_o), .PORT_C_OE(pc_oe), .EPROM_BANK_SELECTS(eprom),
    .SRAM_SELECT(sram), .IO_PORT_SELECT(iosel), .EXT_SELECT_N(ext_n),
    .POWER_DOWN(pd));
  // Prints the verdict and ends the run.
  task automatic close_out();
    if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic Wishbone cycle; read data lands in rd at the ack edge.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [3:0] s, input logic [7:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) begin
      fail_count++;
      $display("[ERR] %0t no bus answer", $time);
      close_out();
    end
  endtask
  // Status image expected when only product term t is true.
  function automatic logic [31:0] exp_stat(input int t);
    logic [31:0] s;
    s = 32'h0;
    if (t < 8) s[t] = 1'b1;
    else if (t == 8) s[20] = 1'b1;
    else if (t == 9) s[21] = 1'b1;
    else if (t >= 13 && t < 29) s[8 + (t - 13) / 4] = 1'b1;
    else if (t >= 29 && t < 37) s[12 + (t - 29) / 2] = 1'b1;
    else if (t >= 37) s[16 + t - 37] = 1'b1;
    return s;
  endfunction
  // Main sequence: registers, every term, Port A pins, standby, resets.
  initial begin
    logic [31:0] e;
    for (int t = 0; t < PDC_NTERMS; t++) begin
      care[t*PDC_NIN +: PDC_NIN] = 16'hf878;
      match[t*PDC_NIN +: PDC_NIN] = {t[4:0], 7'h00, t[5], 3'h0};
    end
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, 8'h10, 4'h1, 8'h00);
    chk(rd, 32'h0);
    wb(1'b1, 8'h10, 4'h0, 8'hff);
    wb(1'b0, 8'h10, 4'h1, 8'h00);
    chk(rd, 32'h0);
    wb(1'b1, 8'h10, 4'h1, 8'ha5);
    wb(1'b1, 8'h18, 4'h1, 8'h3c);
    wb(1'b1, 8'h08, 4'h1, 8'hff);
    for (int t = 0; t < PDC_NTERMS; t++) begin
      host.addr_cycle({t[4:0], 3'h0, 8'h7b}, {3'h0, t[5]});
      repeat (6) @(posedge clk);
      e = exp_stat(t);
      wb(1'b0, 8'h20, 4'h1, 8'h00);
      chk(rd, e);
      chk(32'({eprom, sram, iosel, ~ext_n}),
          32'({e[7:0], e[20], e[21], e[18:8]}));
      chk(32'({pb_o, pb_oe, pc_o, pc_oe}),
          32'({~e[15:8], 8'hff, ~e[18:16], 3'h7}));
    end
    wb(1'b0, 8'h10, 4'h1, 8'h00);
    chk(rd, 32'ha5);
    wb(1'b0, 8'h18, 4'h1, 8'h00);
    chk(rd, 32'h3c);
    wb(1'b0, 8'h08, 4'h1, 8'h00);
    chk(rd, 32'h76);
    wb(1'b0, 8'h24, 4'h1, 8'h00);
    chk(rd, 32'h0);
    chk(32'({pa_oe, pa_o & pa_oe}), 32'h0000_f574);
    host.addr_cycle({5'h09, 3'h0, 8'h06}, 4'h0);
    host.set_rd(1'b0);
    repeat (5) @(posedge clk);
    chk(32'({ad_oe, ad_o}), 32'h13c);
    host.set_rd(1'b1);
    stby <= 1'b1;
    repeat (6) @(posedge clk);
    chk(32'(pd), 32'h1);
    wb(1'b0, 8'h20, 4'h1, 8'h00);
    chk(rd, 32'h0040_0000);
    stby <= 1'b0;
    rst_pin <= 1'b0;
    repeat (6) @(posedge clk);
    wb(1'b0, 8'h20, 4'h1, 8'h00);
    chk(rd, 32'h0);
    chk(32'(ext_n), 32'h7ff);
    rst_pin <= 1'b1;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, 8'h18, 4'h1, 8'h00);
    chk(rd, 32'h0);
    sbc <= 1'b1;
    stby <= 1'b1;
    repeat (6) @(posedge clk);
    wb(1'b0, 8'h20, 4'h1, 8'h00);
    chk(rd, exp_stat(9));
    close_out();
  end
endmodule
`default_nettype wire
